// ===== core/pefl_defs.svh
// Offsets, field positions, reset values and timing counts of the port event flag latches.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PEFL_DEFS_SVH
`define PEFL_DEFS_SVH

// ==========================================================================
// Register offsets (peek = read only, take = clear on read)
`define PEFL_OFF_CP_PEEK 8'h04
`define PEFL_OFF_CP_TAKE 8'h05
`define PEFL_OFF_UO_PEEK 8'h06
`define PEFL_OFF_UO_TAKE 8'h07
`define PEFL_OFF_OC_PEEK 8'h08
`define PEFL_OFF_OC_TAKE 8'h09

// ==========================================================================
// Field positions: high nibble ports 4..1 at bits 7..4, low nibble at 3..0
`define PEFL_HI_LSB 4
`define PEFL_LO_LSB 0

// ==========================================================================
// Reset values
`define PEFL_FLAGS_RST 8'h00
`define PEFL_RESULT_RST 4'h0

// ==========================================================================
// Timing: read data appears this many cycles after the read strobe
`define PEFL_READ_LAT 1

`endif

// ===== core/pefl_pkg.sv
// Types shared by the port event flag latches.
// Assumes the constants header sits beside it on the include path.
`include "pefl_defs.svh"

package pefl_pkg;

  // ==========================================================================
  // Per-port event pulses, one bit per port (bit 0 = port 1)
  typedef struct packed {
    logic [3:0] port_probe_finished;
    logic [3:0] port_classify_finished;
    logic [3:0] port_unplugged;
    logic [3:0] port_two_pair_overpower;
    logic [3:0] port_overcurrent_timeout;
    logic [3:0] port_startup_overcurrent;
  } pefl_events_t;

  // ==========================================================================
  // Sources of flag clearing other than a clear-on-read access
  typedef struct packed {
    logic [3:0] port_clear;
    logic       quad_reset;
    logic       clear_every_alert_command;
  } pefl_clears_t;

  // ==========================================================================
  // Interrupt summary bits of this quad
  typedef struct packed {
    logic probe_summary_bit;
    logic classify_summary_bit;
    logic unplug_summary_bit;
    logic fault_summary_bit;
    logic start_summary_bit;
  } pefl_summary_t;

endpackage

// ===== core/pefl_flags.sv
// Port event flag latches of one four-port quad with peek and take views.
// Assumes events, port states and clears come from logic on the same clock
// and that a serial-bus front end presents one-cycle register read strobes.
//
// Contract
// - Lower address peeks, next address reads and clears
// - Classification update sets port bits 7..4
// - Detection update sets port bits 3..0
// - Change-only option: flag only on differing result
// - Any detection flag sets its summary bit
// - Classification updates pair check; sets summary
// - Classification only after valid signature detection
// - Power-good port below maintain current: disconnect
// - Any disconnect flag sets its summary bit
// - Power-good port over policing: power cut
// - Power cut or current fault sets summary
// - Power-good port overcurrent too long: fault
// - Powering port overcurrent too long: start fault
// - Any start fault flag sets its summary
// - Summary clears only when all feeds zero
// - Port and quad clear commands clear flags
`timescale 1ns/1ps
`include "pefl_defs.svh"

module pefl_flags
  import pefl_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Register read port from the serial bus front end
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_addr,
  output logic      [7:0]    reg_rd_data_q,
  output logic               reg_rd_valid_q,
  // Events and port state
  input  wire pefl_events_t  events,
  input  wire logic [15:0]   port_probe_result,
  input  wire logic [3:0]    valid_signature_resistance,
  input  wire logic [3:0]    port_power_good,
  input  wire logic [3:0]    port_power_enable,
  input  wire logic [3:0]    pair_check_in,
  input  wire logic          probe_change_only,
  // Clears
  input  wire pefl_clears_t  clears,
  // Other quad alert level
  input  wire logic          other_quad_alert,
  // Results and outputs
  output logic [3:0]         pair_link_check_result_q,
  output logic [3:0]         port_power_off_q,
  output pefl_summary_t      summary_q,
  output logic               host_alert_pin_n_q
);

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] pefl_both(input logic [3:0] p);
    pefl_both = {p, p};
  endfunction

  function automatic logic [7:0] pefl_take(input logic rd, input logic [7:0] a,
                                           input logic [7:0] off);
    pefl_take = (rd && a == off) ? 8'hFF : 8'h00;
  endfunction

  // ==========================================================================
  // Flag state
  logic [7:0]  cp_q, uo_q, oc_q;
  logic [7:0]  cp_d, uo_d, oc_d;
  logic [7:0]  cp_set, uo_set, oc_set;
  logic [7:0]  clr_common;
  logic [15:0] prev_probe_q;
  logic [3:0]  probe_set, class_set;
  pefl_summary_t sum_d;

  // Detection sets a flag on each update, or only on a real change
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      probe_set[i] = events.port_probe_finished[i] &&
        (!probe_change_only ||
         port_probe_result[i*4 +: 4] != prev_probe_q[i*4 +: 4]);
    end
  end

  // A class flag is never set without a good signature
  assign class_set = events.port_classify_finished & valid_signature_resistance;

  // Power faults count only in the documented port state
  assign cp_set = {class_set, probe_set};
  assign uo_set = {events.port_unplugged & port_power_good,
                   events.port_two_pair_overpower & port_power_good};
  assign oc_set = {events.port_overcurrent_timeout & port_power_good,
                   events.port_startup_overcurrent & port_power_enable
                   & ~port_power_good};

  // Port and quad commands wipe the flags besides a take read
  assign clr_common = pefl_both(clears.port_clear) |
                      {8{clears.quad_reset | clears.clear_every_alert_command}};

  // Set wins over any clear so no event is lost
  assign cp_d = (cp_q & ~(clr_common |
                 pefl_take(reg_rd, reg_addr, `PEFL_OFF_CP_TAKE))) | cp_set;
  assign uo_d = (uo_q & ~(clr_common |
                 pefl_take(reg_rd, reg_addr, `PEFL_OFF_UO_TAKE))) | uo_set;
  assign oc_d = (oc_q & ~(clr_common |
                 pefl_take(reg_rd, reg_addr, `PEFL_OFF_OC_TAKE))) | oc_set;

  // Flag registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cp_q <= `PEFL_FLAGS_RST;
      uo_q <= `PEFL_FLAGS_RST;
      oc_q <= `PEFL_FLAGS_RST;
    end
    else
    begin
      cp_q <= cp_d;
      uo_q <= uo_d;
      oc_q <= oc_d;
    end
  end

  // Previous detection result per port, for the change-only option
  always_ff @(posedge clock)
  begin
    if (rst)
      prev_probe_q <= {4{`PEFL_RESULT_RST}};
    else
      for (int i = 0; i < 4; i++)
        if (events.port_probe_finished[i])
          prev_probe_q[i*4 +: 4] <= port_probe_result[i*4 +: 4];
  end

  // Pair check result follows a classification of either port of the pair
  always_ff @(posedge clock)
  begin
    if (rst)
      pair_link_check_result_q <= 4'h0;
    else
    begin
      if (class_set[0] || class_set[1])
        pair_link_check_result_q[1:0] <= pair_check_in[1:0];
      if (class_set[2] || class_set[3])
        pair_link_check_result_q[3:2] <= pair_check_in[3:2];
    end
  end

  // Power removal request, one cycle per qualified fault
  always_ff @(posedge clock)
  begin
    if (rst)
      port_power_off_q <= 4'h0;
    else
      port_power_off_q <= uo_set[7:4] | uo_set[3:0] | oc_set[7:4] | oc_set[3:0];
  end

  // ==========================================================================
  // Summary bits follow the next flag value so they line up with the flags
  always_comb
  begin
    sum_d.probe_summary_bit    = |cp_d[3:0];
    sum_d.classify_summary_bit = |cp_d[7:4];
    sum_d.unplug_summary_bit   = |uo_d[7:4];
    sum_d.fault_summary_bit    = |uo_d[3:0] | (|oc_d[7:4]);
    sum_d.start_summary_bit    = |oc_d[3:0];
  end

  // Summary bits and the active-low alert, which also watches the other quad
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      summary_q          <= '0;
      host_alert_pin_n_q <= 1'b1;
    end
    else
    begin
      summary_q          <= sum_d;
      host_alert_pin_n_q <= ~((|sum_d) | other_quad_alert);
    end
  end

  // ==========================================================================
  // Read data shows the flags before this cycle's clear takes effect
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rd_data_q  <= 8'h00;
      reg_rd_valid_q <= 1'b0;
    end
    else
    begin
      reg_rd_valid_q <= reg_rd;
      if (reg_rd)
        unique case (reg_addr)
          `PEFL_OFF_CP_PEEK, `PEFL_OFF_CP_TAKE: reg_rd_data_q <= cp_q;
          `PEFL_OFF_UO_PEEK, `PEFL_OFF_UO_TAKE: reg_rd_data_q <= uo_q;
          `PEFL_OFF_OC_PEEK, `PEFL_OFF_OC_TAKE: reg_rd_data_q <= oc_q;
          default:                              reg_rd_data_q <= 8'h00;
        endcase
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  peek_keeps_a: assert property (
    reg_rd && reg_addr == `PEFL_OFF_CP_PEEK && cp_set == 8'h00 && clr_common == 8'h00
    |=> cp_q == $past(cp_q) && reg_rd_data_q == $past(cp_q))
    else $error("peek read changed flags");
  take_clears_a: assert property (
    reg_rd && reg_addr == `PEFL_OFF_OC_TAKE && oc_set == 8'h00
    |=> oc_q == 8'h00 && reg_rd_valid_q)
    else $error("take read left flags set");
  reset_zero_a: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> cp_q == 8'h00 && uo_q == 8'h00 && oc_q == 8'h00)
    else $error("flags not zero after reset");
  probe_flag_a: assert property (
    events.port_probe_finished[0] && !probe_change_only |=> cp_q[0])
    else $error("detection flag not set");
  change_only_a: assert property (
    events.port_probe_finished[1] && probe_change_only && !cp_q[1] && clr_common[1]
    == 1'b0 && port_probe_result[7:4] == prev_probe_q[7:4] |=> !cp_q[1])
    else $error("unchanged detection raised flag");
  class_gate_a: assert property (
    !cp_q[4] && !valid_signature_resistance[0] |=> !cp_q[4])
    else $error("class flag without good signature");
  unplug_cut_a: assert property (
    events.port_unplugged[2] && port_power_good[2] |=> uo_q[6] && port_power_off_q[2])
    else $error("disconnect not handled");
  start_fault_a: assert property (
    events.port_startup_overcurrent[3] && port_power_enable[3] && !port_power_good[3]
    |=> oc_q[3] && summary_q.start_summary_bit)
    else $error("start fault not flagged");
  fault_sum_a: assert property (
    summary_q.fault_summary_bit == ((|uo_q[3:0]) || (|oc_q[7:4])))
    else $error("fault summary mismatch");
  alert_level_a: assert property (
    !other_quad_alert && cp_d == 8'h00 && uo_d == 8'h00 && oc_d == 8'h00
    |=> host_alert_pin_n_q && summary_q == '0)
    else $error("alert stuck with no flags");
  port_clear_a: assert property (
    clears.port_clear[0] && cp_set[4] == 1'b0 && uo_set[4] == 1'b0 |=> !cp_q[4] && !uo_q[4])
    else $error("port clear ignored");
  set_wins_a: assert property (
    reg_rd && reg_addr == `PEFL_OFF_UO_TAKE && uo_set[4] |=> uo_q[4])
    else $error("event lost during take read");

  // ==========================================================================
  // Checks on summaries, flags, pair results, reads, pulses, clears and idle outputs
  reset_outputs_a: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> summary_q == '0 && host_alert_pin_n_q && !reg_rd_valid_q
    && port_power_off_q == 4'h0)
    else $error("outputs not idle after reset");
  unmapped_read_a: assert property (
    reg_rd && (reg_addr < `PEFL_OFF_CP_PEEK || reg_addr > `PEFL_OFF_OC_TAKE)
    |=> reg_rd_data_q == 8'h00 && reg_rd_valid_q)
    else $error("unmapped read returned data");
  class_flag_a: assert property (
    events.port_classify_finished[1] && valid_signature_resistance[1] |=> cp_q[5])
    else $error("class flag not set");
  probe_sum_a: assert property (
    summary_q.probe_summary_bit == (|cp_q[3:0]))
    else $error("detection summary mismatch");
  class_sum_a: assert property (
    summary_q.classify_summary_bit == (|cp_q[7:4]))
    else $error("class summary mismatch");
  pair_latch_a: assert property (
    class_set[2] |=> pair_link_check_result_q[3:2] == $past(pair_check_in[3:2]))
    else $error("pair check not latched");
  unplug_sum_a: assert property (
    summary_q.unplug_summary_bit == (|uo_q[7:4]))
    else $error("disconnect summary mismatch");
  overpower_cut_a: assert property (
    events.port_two_pair_overpower[0] && port_power_good[0]
    |=> uo_q[0] && port_power_off_q[0])
    else $error("power cut not handled");
  overcurrent_cut_a: assert property (
    events.port_overcurrent_timeout[1] && port_power_good[1]
    |=> oc_q[5] && port_power_off_q[1])
    else $error("current limit fault not handled");
  start_sum_a: assert property (
    summary_q.start_summary_bit == (|oc_q[3:0]))
    else $error("start summary mismatch");
  alert_other_a: assert property (
    other_quad_alert |=> !host_alert_pin_n_q)
    else $error("alert ignores other quad");
  clear_all_a: assert property (
    (clears.quad_reset || clears.clear_every_alert_command) && cp_set == 8'h00
    && uo_set == 8'h00 && oc_set == 8'h00 |=> cp_q == 8'h00 && uo_q == 8'h00 && oc_q == 8'h00)
    else $error("quad clear ignored");
  off_pulse_a: assert property (
    port_power_off_q[0] && uo_set[4] == 1'b0 && uo_set[0] == 1'b0 && oc_set[4] == 1'b0
    && oc_set[0] == 1'b0 |=> !port_power_off_q[0])
    else $error("power off request held");

endmodule

// ===== sim/pefl_host.sv
// Host side model: issues register reads on the one-cycle strobe port.
// Assumes the bench calls rd from its own process and owns the clock.
`timescale 1ns/1ps

module pefl_host (
  // Clock
  input  wire logic       clock,
  // Read port
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  input  wire logic [7:0] reg_rd_data_q,
  input  wire logic       reg_rd_valid_q
);
  // Idle bus at time zero
  initial
  begin
    reg_rd   = 1'b0;
    reg_addr = 8'hA5;
  end

  // Gap of idle cycles lets the bench act prompt or slow; idle address is scrambled
  task automatic rd(input int gap, input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rd_valid_q;
    d = reg_rd_data_q;
  endtask
endmodule

// ===== sim/pefl_flags_tb.sv
// Self-checking bench for the port event flag latches.
// Assumes pefl_host drives the read port; the bench drives all other inputs.
`timescale 1ns/1ps

module pefl_flags_tb;
  import pefl_pkg::*;
  logic          clock, rst, reg_rd, co, oq, v, v_q, alert_n_q;
  logic [7:0]    reg_addr, rdata_q, d;
  logic [15:0]   res;
  logic [3:0]    vsr, pg, en, pc, pair_q, poff_q, pr, off;
  pefl_events_t  ev;
  pefl_clears_t  cl;
  pefl_summary_t sum_q;
  logic [7:0]    fl [3];
  logic [3:0]    prev [4];
  logic [31:0]   rs, x;
  int            err_total, num_checks;

  pefl_flags DUT (.clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rd_data_q(rdata_q), .reg_rd_valid_q(v_q), .events(ev),
    .port_probe_result(res), .valid_signature_resistance(vsr), .port_power_good(pg),
    .port_power_enable(en), .pair_check_in(pc), .probe_change_only(co), .clears(cl),
    .other_quad_alert(oq), .pair_link_check_result_q(pair_q),
    .port_power_off_q(poff_q), .summary_q(sum_q), .host_alert_pin_n_q(alert_n_q));
  pefl_host host (.clock(clock), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rd_data_q(rdata_q), .reg_rd_valid_q(v_q));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // Model clears first, then sets: a same-edge event must survive the clear
  task automatic step(input pefl_events_t e, input pefl_clears_t c, input logic [31:0] l);
    logic [4:0] s;
    @(posedge clock);
    {ev, cl, pg, en, vsr, pc, oq, co} <= {e, c, l[7:0], l[11:8], l[15:12], l[17:16]};
    res <= l[31:16] & 16'h3333;
    for (int p = 0; p < 4; p++)
      if (c.port_clear[p] | c.quad_reset | c.clear_every_alert_command)
        for (int r = 0; r < 3; r++) fl[r] &= ~(8'h11 << p);
    for (int p = 0; p < 4; p++)
    begin
      if (e.port_probe_finished[p])
      begin
        fl[0][p] |= !l[16] || (l[16+4*p +: 4] & 4'h3) != prev[p];
        prev[p] = l[16+4*p +: 4] & 4'h3;
      end
      fl[0][p+4] |= e.port_classify_finished[p] & l[8+p];
      if (e.port_classify_finished[p] & l[8+p]) pr[p/2*2 +: 2] = l[12+p/2*2 +: 2];
      fl[1][p+4] |= e.port_unplugged[p] & l[4+p];
      fl[1][p] |= e.port_two_pair_overpower[p] & l[4+p];
      fl[2][p+4] |= e.port_overcurrent_timeout[p] & l[4+p];
      fl[2][p] |= e.port_startup_overcurrent[p] & l[p] & !l[4+p];
      off[p] = (e.port_unplugged[p] | e.port_two_pair_overpower[p]
               | e.port_overcurrent_timeout[p]) & l[4+p]
               | e.port_startup_overcurrent[p] & l[p] & !l[4+p];
    end
    @(posedge clock);
    ev <= '0;
    cl <= '0;
    #1;
    s = {|fl[0][3:0], |fl[0][7:4], |fl[1][7:4], |fl[1][3:0] | |fl[2][7:4], |fl[2][3:0]};
    chk("summary", 8'(sum_q), 8'(s));
    chk("alert", 8'(alert_n_q), 8'(!(|s | l[17])));
    chk("power off", 8'(poff_q), 8'(off));
    chk("pair", 8'(pair_q), 8'(pr));
  endtask

  // Take view clears in the model before the taking edge
  task automatic rdc(input logic [7:0] a, input int gap);
    logic [7:0] e;
    e = (a >= 8'h04 && a <= 8'h09) ? fl[(a - 8'h04) >> 1] : 8'h00;
    if (a >= 8'h04 && a <= 8'h09 && a[0]) fl[(a - 8'h04) >> 1] &= ~e;
    host.rd(gap, a, d, v);
    chk("valid", 8'(v), 8'h01);
    chk($sformatf("reg %h", a), d, e);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Tests need about 25 us; eight times that means a hang
  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst, ev, cl, res, vsr, pg, en, pc, co, oq, pr} = '1;
    {ev, cl, res, vsr, pg, en, pc, co, oq, pr} = '0;
    rs = 32'hEE7E1AD9;
    fl = '{default: 8'h00};
    prev = '{default: 4'h0};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int a = 4; a < 10; a++) rdc(8'(a), 0);
    $display("reset views done");
    // Every event kind; port 4 powering, ports 2 and 4 without a valid signature
    step('1, '0, 32'h0000_557F);
    for (int r = 0; r < 3; r++)
    begin
      rdc(8'(4 + 2 * r), 0);
      rdc(8'(5 + 2 * r), 0);
      rdc(8'(4 + 2 * r), 1);
    end
    $display("event walk done");
    // Event lands on the same edge as the take read
    fork
      rdc(8'h05, 0);
      step(24'h100000, '0, 32'h0000_0000);
    join
    rdc(8'h04, 0);
    $display("collision done");
    // Random traffic, clears and reads, unmapped address included
    for (int i = 0; i < 300; i++)
    begin
      x = xs();
      step(24'(xs() & xs() & xs()), (x[31:28] == 0) ? 6'(x[27:22]) : '0, xs());
      if (x[0]) rdc((x[3:1] > 5) ? 8'h0A : 8'(4 + x[3:1]), int'(x[5:4]));
    end
    $display("random done");
    finish_test();
  end
endmodule
